// File: design/dcra_consts.svh
`ifndef DCRA_CONSTS_SVH
`define DCRA_CONSTS_SVH

// Serial packet: one status bit above a 16-bit data word
`define DCRA_FRAME_BITS 17
`define DCRA_STATUS_BIT 16

// Command words
`define DCRA_CMD_CREG_READ 16'h2980
`define DCRA_CMD_CREG_WRITE 16'h2880
`define DCRA_CMD_DREG_READ_BASE 16'h2D80
`define DCRA_CMD_DREG_WRITE_BASE 16'h2C80
`define DCRA_CMD_DREG_MASK 16'hFFE0

// Responses {status, data}
`define DCRA_RESP_COMPLETE 17'h0FFFF
`define DCRA_RESP_NOT_READY 17'h10000
`define DCRA_RESP_BUS_ERROR 17'h10001
`define DCRA_RESP_ILLEGAL 17'h1FFFF

// Control register select codes
`define DCRA_SEL_CACHE_CONTROL 12'h002
`define DCRA_SEL_ACCESS_CONTROL_0 12'h004
`define DCRA_SEL_ACCESS_CONTROL_1 12'h005
`define DCRA_SEL_ALTERNATE_STACK_POINTER 12'h800
`define DCRA_SEL_VECTOR_BASE 12'h801
`define DCRA_SEL_MAC_FIRST 12'h804
`define DCRA_SEL_MAC_LAST 12'h80B
`define DCRA_SEL_PROCESSOR_STATUS_REG 12'h80E
`define DCRA_SEL_PROGRAM_COUNTER 12'h80F
`define DCRA_SEL_FLASH_BASE_REG 12'hC04
`define DCRA_SEL_SRAM_BASE_REG 12'hC05

// Debug register select and configuration/status layout
`define DCRA_DREG_CONFIG_STATUS 5'h00
`define DCRA_CSR_RESET 32'h00000000
`define DCRA_CSR_BREAK_STATUS_HI 31
`define DCRA_CSR_BREAK_STATUS_LO 28
`define DCRA_CSR_FAULT_BIT 27
`define DCRA_CSR_TRIGGER_BIT 26
`define DCRA_CSR_HALT_BIT 25
`define DCRA_CSR_BREAK_BIT 24
`define DCRA_BREAK_LEVEL1_HIT 4'h2
`define DCRA_BREAK_LEVEL2_HIT 4'h6

`endif

// File: design/dcra_pkg.sv
package dcra_pkg;

    typedef enum logic [2:0] {
        ST_COMMAND = 3'b000,
        ST_SEL_HIGH = 3'b001,
        ST_SEL_LOW = 3'b010,
        ST_DATA_HIGH = 3'b011,
        ST_DATA_LOW = 3'b100,
        ST_EXECUTE = 3'b101,
        ST_READY = 3'b110,
        ST_SEND_LOW = 3'b111
    } dcra_state_t;

    typedef enum logic [1:0] {
        OP_CREG_READ = 2'b00,
        OP_CREG_WRITE = 2'b01,
        OP_DREG_WRITE = 2'b10
    } dcra_op_t;

endpackage

// File: design/dcra_serial_shifter.sv
`timescale 1ns/1ns
`include "dcra_consts.svh"

module dcra_serial_shifter #(
    parameter int FRAME_BITS = `DCRA_FRAME_BITS
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic debugSerialClock,
    input wire logic serialDataIn,
    output logic serialDataOut,
    output logic frameDone,
    output logic [FRAME_BITS-1:0] frameWord,
    input wire logic respLoad,
    input wire logic [FRAME_BITS-1:0] respWord
);

    // The bit counter is five bits wide, so longer frames cannot be served
    if (FRAME_BITS < 2 || FRAME_BITS > 32) begin : gBadFrame
        $error("FRAME_BITS out of range");
    end

    logic clkMeta, clkSync, clkLast;
    logic dataMeta, dataSync;
    logic [FRAME_BITS-1:0] rxShift;
    logic [FRAME_BITS-1:0] txShift;
    logic [4:0] bitCount;

    wire clkRise = clkSync & ~clkLast;
    wire lastBit = (bitCount == 5'(FRAME_BITS - 1));
    wire [FRAME_BITS-1:0] next_rxShift = {rxShift[FRAME_BITS-2:0], dataSync};

    assign serialDataOut = txShift[FRAME_BITS-1];

    always_ff @(posedge ref_clk) begin
        clkMeta <= debugSerialClock;
        clkSync <= clkMeta;
        clkLast <= clkSync;
        dataMeta <= serialDataIn;
        dataSync <= dataMeta;
    end

    // The link clock is slow against ref_clk, so a reply loaded the cycle
    // after a frame is always in place before the next rising edge.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            rxShift <= '0;
            txShift <= '0;
            bitCount <= 5'h00;
            frameDone <= 1'b0;
            frameWord <= '0;
        end else begin
            frameDone <= 1'b0;
            if (respLoad) begin
                txShift <= respWord;
            end else if (clkRise) begin
                txShift <= {txShift[FRAME_BITS-2:0], 1'b0};
            end
            if (clkRise) begin
                rxShift <= next_rxShift;
                bitCount <= lastBit ? 5'h00 : bitCount + 5'h01;
                if (lastBit) begin
                    frameDone <= 1'b1;
                    frameWord <= next_rxShift;
                end
            end
        end
    end

endmodule

// File: design/dcra_debug_ctrl_access.sv
`timescale 1ns/1ns
`include "dcra_consts.svh"

// Operation
// RQ1: Select 0x002 is cache control; 0x004, 0x005 the two access controls.
// RQ2: Select 0x800 is the alternate stack pointer, 0x801 vector base.
// RQ3: Selects 0x804 to 0x80B reach the multiply-accumulate unit registers in order.
// RQ4: Select 0x80E is processor status, 0x80F the program counter.
// RQ5: 0xC04 flash base (optional variant), 0xC05 on-chip RAM base.
// RQ6: Control read takes a 32-bit select, returns longword, high word first.
// RQ7: Unimplemented bits of narrow control registers may read as anything.
// RQ8: Host maps active and alternate stack pointers using the supervisor bit.
// RQ9: Host saves and disables rounding before accumulator reads, restores afterwards.
// RQ10: Host writes extension bytes only after writing the accumulator.
// RQ11: Control write replaces all 32 bits of the selected register.
// RQ12: Control write carries select longword then data longword.
// RQ13: Control write answers 0xFFFF, or status set with 0x0001 on bus error.
// RQ14: Debug read accepts select 0x00 only; 0x01 to 0x1F are reserved.
// RQ15: Status read clears fault, trigger, halt, breakpoint flags and finished breakpoint status.
// RQ16: Debug read takes no operand, returns longword, high word first.
// RQ17: Debug write replaces all 32 bits, data arriving high word first.
// RQ18: Serial clock stays idle while the processor writes debug registers itself.
// RQ19: Completed debug write answers 0xFFFF.
module dcra_debug_ctrl_access
    import dcra_pkg::*;
#(
    parameter bit FLASH_PRESENT = 1'b1
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic debugSerialClock,
    input wire logic serialDataIn,
    output logic serialDataOut,
    output logic cregReq,
    output logic cregWrite,
    output logic [11:0] cregSel,
    output logic [31:0] cregWdata,
    input wire logic cregAck,
    input wire logic cregBusErr,
    input wire logic [31:0] cregRdata,
    input wire logic faultEvent,
    input wire logic triggerEvent,
    input wire logic haltEvent,
    input wire logic breakEvent,
    input wire logic breakStatusLoad,
    input wire logic [3:0] breakStatusValue,
    input wire logic level2Enabled,
    input wire logic cpuDebugWrite,
    input wire logic [31:0] cpuDebugData,
    output logic [31:0] debugConfigStatus
);

    function automatic logic cregSelValid(input logic [11:0] sel, input logic flash);
        logic ok;
        ok = 1'b0;
        case (sel)
            `DCRA_SEL_CACHE_CONTROL, `DCRA_SEL_ACCESS_CONTROL_0,
            `DCRA_SEL_ACCESS_CONTROL_1: ok = 1'b1; // RQ1
            `DCRA_SEL_ALTERNATE_STACK_POINTER, `DCRA_SEL_VECTOR_BASE: ok = 1'b1; // RQ2
            `DCRA_SEL_PROCESSOR_STATUS_REG, `DCRA_SEL_PROGRAM_COUNTER: ok = 1'b1; // RQ4
            `DCRA_SEL_FLASH_BASE_REG: ok = flash; // RQ5
            `DCRA_SEL_SRAM_BASE_REG: ok = 1'b1; // RQ5
            default: ok = (sel >= `DCRA_SEL_MAC_FIRST) && (sel <= `DCRA_SEL_MAC_LAST); // RQ3
        endcase
        return ok;
    endfunction

    logic frameDone;
    logic [16:0] frameWord;
    logic respLoad;
    logic [16:0] respWord;
    dcra_state_t state;
    dcra_op_t op;
    logic [31:0] selLatch;
    logic [15:0] dataHigh;
    logic [31:0] resultLatch;
    logic resultErr;
    logic csrReadClear;
    logic csrHostWrite;
    logic [31:0] csrHostData;

    dcra_serial_shifter #(
        .FRAME_BITS(`DCRA_FRAME_BITS)
    ) shifter (
        .ref_clk(ref_clk),
        .reset(reset),
        .debugSerialClock(debugSerialClock),
        .serialDataIn(serialDataIn),
        .serialDataOut(serialDataOut),
        .frameDone(frameDone),
        .frameWord(frameWord),
        .respLoad(respLoad),
        .respWord(respWord)
    );

    wire [15:0] inWord = frameWord[15:0];
    wire isCregRead = (inWord == `DCRA_CMD_CREG_READ);
    wire isCregWrite = (inWord == `DCRA_CMD_CREG_WRITE);
    wire isDregRead = ((inWord & `DCRA_CMD_DREG_MASK) == `DCRA_CMD_DREG_READ_BASE);
    wire isDregWrite = ((inWord & `DCRA_CMD_DREG_MASK) == `DCRA_CMD_DREG_WRITE_BASE);
    wire dregSelOk = (inWord[4:0] == `DCRA_DREG_CONFIG_STATUS); // RQ14
    wire [31:0] fullSel = {selLatch[31:16], inWord};
    wire selOk = cregSelValid(fullSel[11:0], FLASH_PRESENT) && (fullSel[31:12] == 20'h00000);
    wire [31:0] fullData = {dataHigh, inWord};

    // Sticky flags: hardware events win over the clear that a host read causes
    // Clear on the capturing edge itself, so no event can slip in between and vanish
    assign csrReadClear = frameDone && (state == ST_COMMAND) && isDregRead && dregSelOk; // RQ15
    wire [3:0] curBreakStatus =
        debugConfigStatus[`DCRA_CSR_BREAK_STATUS_HI:`DCRA_CSR_BREAK_STATUS_LO];
    wire breakStatusDone = (curBreakStatus == `DCRA_BREAK_LEVEL2_HIT)
                           || ((curBreakStatus == `DCRA_BREAK_LEVEL1_HIT) && !level2Enabled);
    wire [3:0] eventBits = {faultEvent, triggerEvent, haltEvent, breakEvent};
    wire [3:0] keptFlags = csrReadClear ? 4'h0
                           : debugConfigStatus[`DCRA_CSR_FAULT_BIT:`DCRA_CSR_BREAK_BIT]; // RQ15
    wire [3:0] keptBreakStatus = (csrReadClear && breakStatusDone) ? 4'h0
                                 : curBreakStatus; // RQ15
    wire [31:0] next_debugConfigStatus = {breakStatusLoad ? breakStatusValue : keptBreakStatus,
                                          keptFlags | eventBits,
                                          debugConfigStatus[23:0]};

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            debugConfigStatus <= `DCRA_CSR_RESET;
        end else if (csrHostWrite) begin
            debugConfigStatus <= csrHostData; // RQ17
        end else if (cpuDebugWrite) begin
            // No interlock: the host keeps the serial clock idle meanwhile
            debugConfigStatus <= cpuDebugData; // RQ18
        end else begin
            debugConfigStatus <= next_debugConfigStatus;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state <= ST_COMMAND;
            op <= OP_CREG_READ;
            selLatch <= 32'h00000000;
            dataHigh <= 16'h0000;
            resultLatch <= 32'h00000000;
            resultErr <= 1'b0;
            respLoad <= 1'b0;
            respWord <= `DCRA_RESP_COMPLETE;
            cregReq <= 1'b0;
            cregWrite <= 1'b0;
            cregSel <= 12'h000;
            cregWdata <= 32'h00000000;
            csrHostWrite <= 1'b0;
            csrHostData <= 32'h00000000;
        end else begin
            respLoad <= frameDone;
            cregReq <= 1'b0;
            csrHostWrite <= 1'b0;
            if (state == ST_EXECUTE && cregAck) begin
                resultLatch <= cregRdata; // RQ7
                resultErr <= cregBusErr;
                state <= ST_READY;
            end
            if (frameDone) begin
                respWord <= `DCRA_RESP_NOT_READY;
                case (state)
                    ST_COMMAND: begin
                        if (isCregRead) begin
                            op <= OP_CREG_READ;
                            state <= ST_SEL_HIGH; // RQ6
                        end else if (isCregWrite) begin
                            op <= OP_CREG_WRITE;
                            state <= ST_SEL_HIGH; // RQ12
                        end else if (isDregRead && dregSelOk) begin
                            respWord <= {1'b0, debugConfigStatus[31:16]}; // RQ16
                            resultLatch <= debugConfigStatus;
                            state <= ST_SEND_LOW;
                        end else if (isDregWrite && dregSelOk) begin
                            op <= OP_DREG_WRITE;
                            state <= ST_DATA_HIGH;
                        end else begin
                            respWord <= `DCRA_RESP_ILLEGAL; // RQ14
                        end
                    end
                    ST_SEL_HIGH: begin
                        selLatch <= {inWord, 16'h0000};
                        state <= ST_SEL_LOW;
                    end
                    ST_SEL_LOW: begin
                        selLatch <= fullSel;
                        if (!selOk) begin
                            // Unmapped selects never reach the core
                            resultErr <= 1'b1;
                            state <= (op == OP_CREG_WRITE) ? ST_DATA_HIGH : ST_READY;
                        end else if (op == OP_CREG_WRITE) begin
                            resultErr <= 1'b0;
                            state <= ST_DATA_HIGH;
                        end else begin
                            resultErr <= 1'b0;
                            cregReq <= 1'b1;
                            cregWrite <= 1'b0;
                            cregSel <= fullSel[11:0];
                            state <= ST_EXECUTE;
                        end
                    end
                    ST_DATA_HIGH: begin
                        dataHigh <= inWord; // RQ17
                        state <= ST_DATA_LOW;
                    end
                    ST_DATA_LOW: begin
                        if (op == OP_DREG_WRITE) begin
                            csrHostWrite <= 1'b1;
                            csrHostData <= fullData;
                            respWord <= `DCRA_RESP_COMPLETE; // RQ19
                            state <= ST_COMMAND;
                        end else if (resultErr) begin
                            state <= ST_READY;
                        end else begin
                            cregReq <= 1'b1;
                            cregWrite <= 1'b1;
                            cregSel <= selLatch[11:0];
                            cregWdata <= fullData; // RQ11
                            state <= ST_EXECUTE;
                        end
                    end
                    ST_EXECUTE: begin
                        // An answer in the same cycle as a filler frame must not be lost
                        state <= cregAck ? ST_READY : ST_EXECUTE;
                    end
                    ST_READY: begin
                        if (resultErr) begin
                            respWord <= `DCRA_RESP_BUS_ERROR; // RQ13
                            state <= ST_COMMAND;
                        end else if (op == OP_CREG_WRITE) begin
                            respWord <= `DCRA_RESP_COMPLETE; // RQ13
                            state <= ST_COMMAND;
                        end else begin
                            respWord <= {1'b0, resultLatch[31:16]}; // RQ6
                            state <= ST_SEND_LOW;
                        end
                    end
                    ST_SEND_LOW: begin
                        respWord <= {1'b0, resultLatch[15:0]}; // RQ6
                        state <= ST_COMMAND;
                    end
                    default: begin
                        state <= ST_COMMAND;
                    end
                endcase
            end
        end
    end

endmodule

// File: dv/dcra_debug_ctrl_access_asserts.sv
`timescale 1ns/1ns
module dcra_debug_ctrl_access_asserts (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic cregReq,
    input wire logic cregWrite,
    input wire logic [11:0] cregSel,
    input wire logic [31:0] cregWdata,
    input wire logic cregAck,
    input wire logic faultEvent,
    input wire logic triggerEvent,
    input wire logic haltEvent,
    input wire logic breakEvent,
    input wire logic breakStatusLoad,
    input wire logic [3:0] breakStatusValue,
    input wire logic cpuDebugWrite,
    input wire logic [31:0] cpuDebugData,
    input wire logic [31:0] debugConfigStatus
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    logic waiting;
    logic selMapped;
    logic [3:0] evt;
    assign evt = {faultEvent, triggerEvent, haltEvent, breakEvent};
    assign selMapped = cregSel inside {12'h002, 12'h004, 12'h005, 12'h800, 12'h801,
        [12'h804:12'h80B], 12'h80E, 12'h80F, 12'hC04, 12'hC05};
    always_ff @(posedge ref_clk) begin
        if (reset || cregAck) begin
            waiting <= 1'h0;
        end else if (cregReq) begin
            waiting <= 1'h1;
        end
    end
    sequence s_pulse;
        cregReq ##1 !cregReq;
    endsequence
    sequence s_evt_seen;
        (|evt) && !cpuDebugWrite;
    endsequence
    property p_sel_map;
        cregReq |-> selMapped;
    endproperty
    property p_req_pulse;
        cregReq |-> s_pulse;
    endproperty
    property p_one_outstanding;
        cregReq |-> !waiting;
    endproperty
    property p_fields_hold;
        !cregReq |-> $stable({cregWrite, cregSel, cregWdata});
    endproperty
    property p_evt_set;
        s_evt_seen |=> (debugConfigStatus[27:24] & $past(evt)) == $past(evt);
    endproperty
    property p_status_load;
        breakStatusLoad && !cpuDebugWrite |=> debugConfigStatus[31:28] == $past(breakStatusValue);
    endproperty
    property p_cpu_write;
        cpuDebugWrite |=> debugConfigStatus == $past(cpuDebugData);
    endproperty
    property p_csr_reset;
        $fell(reset) |-> debugConfigStatus == 32'h00000000;
    endproperty
    a_sel_map: assert property (p_sel_map) else $error("select outside map");
    a_req_pulse: assert property (p_req_pulse) else $error("request not one cycle");
    a_one_outstanding: assert property (p_one_outstanding) else $error("second access");
    a_fields_hold: assert property (p_fields_hold) else $error("fields moved");
    a_evt_set: assert property (p_evt_set) else $error("event flag not set");
    a_status_load: assert property (p_status_load) else $error("status not loaded");
    a_cpu_write: assert property (p_cpu_write) else $error("cpu write lost");
    a_csr_reset: assert property (p_csr_reset) else $error("status not cleared");
endmodule

bind dcra_debug_ctrl_access dcra_debug_ctrl_access_asserts u_asserts (
    .ref_clk(ref_clk),
    .reset(reset),
    .cregReq(cregReq),
    .cregWrite(cregWrite),
    .cregSel(cregSel),
    .cregWdata(cregWdata),
    .cregAck(cregAck),
    .faultEvent(faultEvent),
    .triggerEvent(triggerEvent),
    .haltEvent(haltEvent),
    .breakEvent(breakEvent),
    .breakStatusLoad(breakStatusLoad),
    .breakStatusValue(breakStatusValue),
    .cpuDebugWrite(cpuDebugWrite),
    .cpuDebugData(cpuDebugData),
    .debugConfigStatus(debugConfigStatus)
);

// File: dv/dcra_host_model.sv
`timescale 1ns/1ns
module dcra_host_model (
    input wire logic ref_clk,
    output logic debugSerialClock,
    output logic serialDataIn,
    input wire logic serialDataOut
);
    initial begin
        debugSerialClock = 1'h0;
        serialDataIn = 1'h0;
    end
    // Link clock runs only inside frames; reply bits are taken just before each rise
    task automatic xfer(input logic [16:0] tx, output logic [16:0] rx);
        @(posedge ref_clk);
        #23;
        for (int i = 16; i >= 0; i--) begin
            serialDataIn = tx[i];
            #400;
            rx[i] = serialDataOut;
            debugSerialClock = 1'h1;
            #400;
            debugSerialClock = 1'h0;
        end
        // Released line shows the inverse so a stale bit cannot pass as data
        serialDataIn = ~tx[0];
        #1000;
    endtask
endmodule

// File: dv/dcra_debug_ctrl_access_test.sv
`timescale 1ns/1ns
`include "dcra_consts.svh"
module dcra_debug_ctrl_access_test;
    logic ref_clk, debugSerialClock, serialDataIn, serialDataOut, cregReq, cregWrite, lastWr;
    logic reset = 1'h1, cregAck = 1'h0, cregBusErr = 1'h0, level2Enabled = 1'h0, errNext = 1'h0;
    logic faultEvent = 1'h0, triggerEvent = 1'h0, haltEvent = 1'h0, breakEvent = 1'h0;
    logic breakStatusLoad = 1'h0, cpuDebugWrite = 1'h0;
    logic [3:0] breakStatusValue = 4'h0;
    logic [11:0] cregSel, lastSel;
    logic [31:0] cregWdata, debugConfigStatus, lastData, cregRdata = 32'h0, cpuDebugData = 32'h0;
    logic [31:0] coreRegs [logic [11:0]];
    logic [16:0] rx;
    int ackDelay = 1, ackCnt = 0, reqCount = 0, n_mismatch = 0, checks_done = 0;
    logic [11:0] mapSel [17] = '{12'h002, 12'h004, 12'h005, 12'h800, 12'h801, 12'h804, 12'h805,
        12'h806, 12'h809, 12'h80A, 12'h80B, 12'h807, 12'h808, 12'h80E, 12'h80F, 12'hC04, 12'hC05};
    logic [11:0] badSel [5] = '{12'h000, 12'h003, 12'h80C, 12'h80D, 12'hC06};
    logic [31:0] csrIn [4] = '{32'h6F00A5C3, 32'h2F000001, 32'h2F000001, 32'h5F00FFFF};
    logic [31:0] csrOut [4] = '{32'h0000A5C3, 32'h20000001, 32'h00000001, 32'h5000FFFF};
    logic l2En [4] = '{1'h0, 1'h1, 1'h0, 1'h1};

    dcra_debug_ctrl_access dut (.ref_clk(ref_clk), .reset(reset),
        .debugSerialClock(debugSerialClock), .serialDataIn(serialDataIn),
        .serialDataOut(serialDataOut), .cregReq(cregReq), .cregWrite(cregWrite),
        .cregSel(cregSel), .cregWdata(cregWdata), .cregAck(cregAck), .cregBusErr(cregBusErr),
        .cregRdata(cregRdata), .faultEvent(faultEvent), .triggerEvent(triggerEvent),
        .haltEvent(haltEvent), .breakEvent(breakEvent), .breakStatusLoad(breakStatusLoad),
        .breakStatusValue(breakStatusValue),
        .level2Enabled(level2Enabled), .cpuDebugWrite(cpuDebugWrite),
        .cpuDebugData(cpuDebugData), .debugConfigStatus(debugConfigStatus));
    dcra_host_model host (.ref_clk(ref_clk), .debugSerialClock(debugSerialClock),
        .serialDataIn(serialDataIn), .serialDataOut(serialDataOut));

    initial begin
        ref_clk = 1'h0;
        forever #50 ref_clk = ~ref_clk;
    end

    // Core side: answers after ackDelay cycles; read data churns outside the answer
    always @(posedge ref_clk) begin
        if (ackCnt == 1) begin
            cregAck <= 1'h1;
            cregBusErr <= errNext;
            cregRdata <= coreRegs.exists(lastSel) ? coreRegs[lastSel] : 32'h0;
            if (lastWr && !errNext) coreRegs[lastSel] = lastData;
        end else begin
            cregAck <= 1'h0;
            cregRdata <= ~cregRdata;
        end
        if (ackCnt > 0) ackCnt--;
        if (cregReq) begin
            reqCount++;
            {lastWr, lastSel, lastData} = {cregWrite, cregSel, cregWdata};
            ackCnt = ackDelay;
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic send(input logic [15:0] w);
        host.xfer({1'h0, w}, rx);
    endtask
    task automatic poll();
        for (int k = 0; k < 30 && rx === `DCRA_RESP_NOT_READY; k++) send(16'h0000);
    endtask
    task automatic creg_write(input logic [31:0] sel, input logic [31:0] d, input logic [16:0] e);
        send(`DCRA_CMD_CREG_WRITE);
        send(sel[31:16]);
        send(sel[15:0]);
        send(d[31:16]);
        send(d[15:0]);
        poll();
        chk({15'h0, rx}, {15'h0, e});
    endtask
    task automatic creg_read(input logic [31:0] sel, input logic [31:0] e);
        send(`DCRA_CMD_CREG_READ);
        send(sel[31:16]);
        send(sel[15:0]);
        poll();
        chk({15'h0, rx}, {16'h0, e[31:16]});
        send(16'h0000);
        chk({15'h0, rx}, {16'h0, e[15:0]});
    endtask
    task automatic dreg_write(input logic [31:0] d);
        send(`DCRA_CMD_DREG_WRITE_BASE);
        send(d[31:16]);
        send(d[15:0]);
        send(16'h0000);
        chk({15'h0, rx}, {15'h0, `DCRA_RESP_COMPLETE});
        chk(debugConfigStatus, d);
    endtask
    task automatic dreg_read(input logic [31:0] e);
        send(`DCRA_CMD_DREG_READ_BASE);
        send(16'h0000);
        chk({15'h0, rx}, {16'h0, e[31:16]});
        send(16'h0000);
        chk({15'h0, rx}, {16'h0, e[15:0]});
    endtask
    task automatic refused(input logic [15:0] cmd);
        send(cmd);
        send(16'h0000);
        chk({15'h0, rx}, {15'h0, `DCRA_RESP_ILLEGAL});
    endtask
    task automatic pulse(input logic [3:0] e, input logic ld, input logic cw);
        @(posedge ref_clk);
        breakStatusValue <= 4'h2;
        cpuDebugData <= 32'h00003C3C;
        {faultEvent, triggerEvent, haltEvent, breakEvent} <= e;
        {breakStatusLoad, cpuDebugWrite} <= {ld, cw};
        @(posedge ref_clk);
        {faultEvent, triggerEvent, haltEvent, breakEvent} <= 4'h0;
        {breakStatusLoad, cpuDebugWrite} <= 2'h0;
        repeat (2) @(posedge ref_clk);
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        repeat (90000) @(posedge ref_clk);
        n_mismatch++;
        complete_run();
    end

    initial begin
        logic [31:0] d;
        repeat (10) @(posedge ref_clk);
        reset <= 1'h0;
        repeat (3) @(posedge ref_clk);
        // Accumulators go before their extension bytes
        foreach (mapSel[i]) begin
            ackDelay = (i % 2) ? 7 : 1;
            d = {4'hA, mapSel[i], 16'h5C30 + 16'(i)};
            creg_write({20'h0, mapSel[i]}, d, `DCRA_RESP_COMPLETE);
            chk({19'h0, lastWr, lastSel}, {20'h1, mapSel[i]});
            chk(lastData, d);
            creg_read({20'h0, mapSel[i]}, d);
            chk({19'h0, lastWr, lastSel}, {20'h0, mapSel[i]});
        end
        foreach (badSel[i]) creg_write({20'h0, badSel[i]}, 32'h0, `DCRA_RESP_BUS_ERROR);
        creg_write(32'h00010801, 32'h0, `DCRA_RESP_BUS_ERROR);
        chk(32'(reqCount), 32'h22);
        errNext = 1'h1;
        creg_write(32'h00000801, 32'h12345678, `DCRA_RESP_BUS_ERROR);
        errNext = 1'h0;
        // Save the accumulator status, clear it, read an accumulator, then restore
        creg_read(32'h00000804, 32'hA8045C35);
        creg_write(32'h00000804, 32'h00000000, `DCRA_RESP_COMPLETE);
        creg_read(32'h00000806, 32'hA8065C37);
        creg_write(32'h00000804, 32'hA8045C35, `DCRA_RESP_COMPLETE);
        // Status register first, so the host knows which stack pointer is which
        creg_read(32'h0000080E, 32'hA80E5C3D);
        creg_read(32'h00000800, 32'hA8005C33);
        foreach (csrIn[i]) begin
            @(posedge ref_clk);
            level2Enabled <= l2En[i];
            dreg_write(csrIn[i]);
            dreg_read(csrIn[i]);
            chk(debugConfigStatus, csrOut[i]);
        end
        dreg_write(32'h0F000000);
        for (int s = 1; s < 32; s += 15) refused(`DCRA_CMD_DREG_READ_BASE | 16'(s));
        refused(`DCRA_CMD_DREG_WRITE_BASE | 16'h0001);
        refused(16'h1234);
        chk(debugConfigStatus, 32'h0F000000);
        // Link clock stays idle while the processor writes the status register
        pulse(4'h0, 1'h0, 1'h1);
        chk(debugConfigStatus, 32'h00003C3C);
        pulse(4'hA, 1'h1, 1'h0);
        chk(debugConfigStatus, 32'h2A003C3C);
        dreg_read(32'h2A003C3C);
        chk(debugConfigStatus, 32'h20003C3C);
        pulse(4'h5, 1'h0, 1'h0);
        chk(debugConfigStatus, 32'h25003C3C);
        dreg_read(32'h25003C3C);
        chk(debugConfigStatus, 32'h20003C3C);
        @(posedge ref_clk);
        reset <= 1'h1;
        repeat (3) @(posedge ref_clk);
        reset <= 1'h0;
        repeat (2) @(posedge ref_clk);
        chk(debugConfigStatus, 32'h00000000);
        dreg_read(32'h00000000);
        complete_run();
    end
endmodule
